// ### core/event_sleep_pkg.sv
// Purpose: shared constants and types for the event status and sleep block
// Assumes: 125 MHz system clock, serial frame of 8 command bits then 16 data bits
// Notes: register addresses are 5-bit command-byte fields

package event_sleep_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int NS_PER_US = 1000;

    // ----------------------------------------------------------------
    // serial frame layout
    // ----------------------------------------------------------------
    localparam int CMD_READ_BIT = 7;
    localparam int ADDR_MSB = 4;
    localparam logic [3:0] CMD_LAST_BIT = 4'h7;
    localparam logic [3:0] DATA_LAST_BIT = 4'hF;
    localparam logic [2:0] LINK_SYNC_RESET = 3'h2;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_EVENT_FLAGS = 5'h00;
    localparam logic [4:0] ADDR_EVENT_MASK = 5'h01;
    localparam logic [4:0] ADDR_CONTROL = 5'h02;
    localparam logic [4:0] ADDR_PIN_CONFIG = 5'h03;
    localparam logic [4:0] ADDR_SLEEP = 5'h04;
    localparam logic [4:0] ADDR_NORMAL = 5'h05;
    localparam logic [4:0] ADDR_SLEEP_CFG = 5'h06;
    localparam logic [4:0] ADDR_STATE = 5'h07;

    // ----------------------------------------------------------------
    // event flag positions and values
    // ----------------------------------------------------------------
    localparam int FLAG_LOW_LOGIC = 15;
    localparam int FLAG_LOW_PUMP = 14;
    localparam int FLAG_RANGE = 13;
    localparam int FLAG_SIGNAL = 12;
    localparam int FLAG_LOCKED = 11;
    localparam int FLAG_CONV_DONE = 10;
    localparam int FLAG_ALARM = 9;
    localparam int FLAG_UNUSED = 8;
    localparam int FLAG_RISE_LSB = 4;
    localparam int FLAG_FALL_LSB = 0;
    localparam logic [15:0] EVENT_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'hF6FF;
    localparam logic [15:0] MASK_WRITABLE = 16'hFEFF;
    localparam logic [15:0] READ_CLEAR_MASK = 16'hDAFF;

    // ----------------------------------------------------------------
    // user pin functions, two bits per pin
    // ----------------------------------------------------------------
    localparam logic [1:0] PIN_FN_INPUT = 2'h0;
    localparam logic [1:0] PIN_FN_RESULT_OUT = 2'h1;
    localparam logic [1:0] PIN_FN_SLEEP = 2'h2;
    localparam logic [1:0] PIN_FN_WAKE = 2'h3;
    localparam logic [7:0] PIN_CONFIG_RESET = 8'h00;
    localparam logic [3:0] PINS_SYNC_RESET = 4'hF;

    // ----------------------------------------------------------------
    // sleep config and state register fields
    // ----------------------------------------------------------------
    localparam int SLEEP_REQ_BIT = 0;
    localparam int STATE_SLEEP_BIT = 0;
    localparam int STATE_CLKOUT_BIT = 1;
    localparam int STATE_BLANK_BIT = 2;
    localparam int STATE_PINS_LSB = 4;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic bipolar_mode;
        logic day_alarm_enable;
        logic lock_loop_enable;
        logic comparator_power_enable;
        logic converter_enable;
        logic pump_monitor_enable;
        logic logic_monitor_enable;
    } ctrl_t;
    localparam logic [6:0] CTRL_RESET = 7'h01;

    typedef struct packed {
        logic valid;
        logic signed [17:0] value;
    } conv_result_t;

    typedef enum logic [1:0] {F_IDLE, F_CMD, F_DATA, F_END} frame_state_t;

endpackage

// ### core/sync_2ff.sv
// Purpose: two flip-flop synchroniser for levels from outside the clock domain
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps

module sync_2ff #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_reg <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // sync_2ff

// ### core/edge_detect.sv
// Purpose: rise and fall pulses for already synchronised levels
// Assumes: input is in the clock domain
// Notes: pulses last one clock
`timescale 1ns/100ps

module edge_detect #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] prev_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prev_reg <= RESET_VAL;
        end else begin
            prev_reg <= level;
        end
    end

    assign rise = level & ~prev_reg;
    assign fall = ~level & prev_reg;
endmodule // edge_detect

// ### core/event_sleep_control.sv
// Purpose: event flags, interrupt, serial register port and sleep control
// Assumes: host drives sclk/cs_n/mosi, device shifts out on sclk rise
// Notes: all pins are sampled through two flip-flops on the system clock
//
// How it works
// - interrupt asserts for any unmasked set flag
// - flags latch events even when masked
// - full read clears all but two flags
// - interrupt blanked from first data bit to end
// - aborted read leaves every flag unchanged
// - events during read re-interrupt after read
// - low logic-supply flag follows enabled monitor
// - low pump-output flag follows enabled monitor
// - range-error flag from result limits per mode
// - signal-detect flag set by comparator, cleared off
// - clock-locked flag set on lock, read clears
// - converter-done flag mirrors result ready signal
// - day-alarm flag on match, cleared by disable
// - pin rise and fall flags for all pins
// - event register resets to zero, fixed layout
// - pin-routed outputs have no mask bits
// - reset enables logic monitor, pins pulled-up inputs
// - clock outputs after supervisor clear and timeout
// - sleep by address, request bit or pin
// - sleep is latch OR sleep pin
// - normal address or pin release exits sleep
// - wake pin or alarm exits sleep
// - mask bit one suppresses, only lock enabled
// - wake in normal mode only records event
`timescale 1ns/100ps

module event_sleep_control
    import event_sleep_pkg::*;
#(
    parameter int TIMEOUT_US = 100
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    output logic irq_n,
    input wire logic [3:0] user_pins_in,
    output logic [3:0] user_pins_out,
    output logic [3:0] user_pins_oe,
    output logic [3:0] user_pins_pullup,
    input wire logic logic_supply_low,
    input wire logic pump_output_low,
    input wire logic signal_detect_trip,
    input wire logic fll_locked,
    input wire logic supervisor_ok,
    input wire logic result_ready_signal,
    input wire conv_result_t conv_result,
    input wire logic [19:0] time_count,
    input wire logic [19:0] alarm_compare_value,
    output logic sleep_mode,
    output logic clk_out_enable,
    output ctrl_t ctrl
);
    localparam int TIMEOUT_CYCLES_RAW = (TIMEOUT_US * NS_PER_US) / CLK_PERIOD_NS;
    localparam int TIMEOUT_CYCLES = (TIMEOUT_CYCLES_RAW < 1) ? 1 : TIMEOUT_CYCLES_RAW;

    // ----------------------------------------------------------------
    // input synchronisers and edge finders
    // ----------------------------------------------------------------
    logic [2:0] link_s;
    logic [3:0] pins_s;
    logic [4:0] mon_s;
    logic sclk_s, cs_s, mosi_s;
    logic sclk_rise, sclk_fall;
    logic [3:0] pin_rise, pin_fall;
    logic lock_rise;

    sync_2ff #(.WIDTH(3), .RESET_VAL(LINK_SYNC_RESET)) u_link_sync (
        .clock(clock),
        .rst(rst),
        .d({sclk, cs_n, mosi}),
        .q(link_s)
    );
    sync_2ff #(.WIDTH(4), .RESET_VAL(PINS_SYNC_RESET)) u_pins_sync (
        .clock(clock),
        .rst(rst),
        .d(user_pins_in),
        .q(pins_s)
    );
    sync_2ff #(.WIDTH(5), .RESET_VAL(5'h00)) u_mon_sync (
        .clock(clock),
        .rst(rst),
        .d({logic_supply_low, pump_output_low, signal_detect_trip, fll_locked,
            supervisor_ok}),
        .q(mon_s)
    );

    assign sclk_s = link_s[2];
    assign cs_s = link_s[1];
    assign mosi_s = link_s[0];

    edge_detect #(.WIDTH(1), .RESET_VAL(1'b0)) u_sclk_edge (
        .clock(clock),
        .rst(rst),
        .level(sclk_s),
        .rise(sclk_rise),
        .fall(sclk_fall)
    );
    // pins: edges seen whatever the pin function, outputs included
    edge_detect #(.WIDTH(4), .RESET_VAL(PINS_SYNC_RESET)) u_pin_edge (
        .clock(clock),
        .rst(rst),
        .level(pins_s),
        .rise(pin_rise),
        .fall(pin_fall)
    );
    edge_detect #(.WIDTH(1), .RESET_VAL(1'b0)) u_lock_edge (
        .clock(clock),
        .rst(rst),
        .level(mon_s[1]),
        .rise(lock_rise),
        .fall()
    );

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    frame_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] cmd_reg;
    logic [15:0] data_sh_reg;
    logic [15:0] flags_reg, flags_next;
    logic [15:0] snap_reg;
    logic [15:0] mask_reg;
    logic [7:0] pin_cfg_reg;
    logic blank_reg;
    logic shutdown_latch, latch_next;
    logic match_prev_reg;
    logic [31:0] timeout_cnt_reg;
    logic [15:0] rdata;
    logic [7:0] cmd_next;
    logic cmd_done, first_data_rise, write_strobe, ev_read, read_done;
    logic sleep_cmd, normal_cmd;
    logic [15:0] wdata;
    logic [15:0] set_vec, zero_vec, clr_vec;
    logic alarm_match, alarm_hit, range_bad;
    logic sleep_pin, wake_hit;

    // ----------------------------------------------------------------
    // serial frame decode
    // ----------------------------------------------------------------
    assign cmd_next = {cmd_reg[6:0], mosi_s};
    assign cmd_done = (state_reg == F_CMD) && sclk_rise && (bit_cnt_reg == CMD_LAST_BIT);
    assign sleep_cmd = cmd_done && !cmd_next[CMD_READ_BIT]
                       && (cmd_next[ADDR_MSB:0] == ADDR_SLEEP);
    assign normal_cmd = cmd_done && !cmd_next[CMD_READ_BIT]
                        && (cmd_next[ADDR_MSB:0] == ADDR_NORMAL);
    assign first_data_rise = (state_reg == F_DATA) && sclk_rise && (bit_cnt_reg == 4'h0);
    assign write_strobe = (state_reg == F_DATA) && sclk_rise
                          && (bit_cnt_reg == DATA_LAST_BIT) && !cmd_reg[CMD_READ_BIT];
    assign wdata = {data_sh_reg[14:0], mosi_s};
    assign ev_read = cmd_reg[CMD_READ_BIT] && (cmd_reg[ADDR_MSB:0] == ADDR_EVENT_FLAGS);
    // complete read: last bit held until the following fall or the frame end
    assign read_done = blank_reg && (state_reg == F_END) && (sclk_fall || cs_s);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= F_IDLE;
            bit_cnt_reg <= 4'h0;
            cmd_reg <= 8'h00;
            data_sh_reg <= 16'h0000;
            miso <= 1'b0;
        end else if (cs_s) begin
            state_reg <= F_IDLE;
            bit_cnt_reg <= 4'h0;
        end else begin
            case (state_reg)
                F_IDLE: begin
                    state_reg <= F_CMD;
                    bit_cnt_reg <= 4'h0;
                end
                F_CMD: begin
                    if (sclk_rise) begin
                        cmd_reg <= cmd_next;
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (cmd_done) begin
                            bit_cnt_reg <= 4'h0;
                            // sleep and normal addresses carry no data
                            if (sleep_cmd || normal_cmd) begin
                                state_reg <= F_END;
                            end else begin
                                state_reg <= F_DATA;
                            end
                        end
                    end
                end
                F_DATA: begin
                    if (sclk_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (first_data_rise) begin
                            miso <= rdata[15];
                            data_sh_reg <= {rdata[14:0], mosi_s};
                        end else begin
                            miso <= data_sh_reg[15];
                            data_sh_reg <= wdata;
                        end
                        if (bit_cnt_reg == DATA_LAST_BIT) begin
                            state_reg <= F_END;
                        end
                    end
                end
                F_END: begin
                    state_reg <= F_END;
                end
                default: begin
                    state_reg <= F_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= !cs_s;
        end
    end

    // ----------------------------------------------------------------
    // read data mux
    // ----------------------------------------------------------------
    always_comb begin
        rdata = 16'h0000;
        case (cmd_reg[ADDR_MSB:0])
            ADDR_EVENT_FLAGS: rdata = flags_reg;
            ADDR_EVENT_MASK: rdata = mask_reg;
            ADDR_CONTROL: rdata = {9'h000, ctrl};
            ADDR_PIN_CONFIG: rdata = {8'h00, pin_cfg_reg};
            ADDR_SLEEP_CFG: rdata = {15'h0000, shutdown_latch};
            ADDR_STATE: begin
                rdata[STATE_SLEEP_BIT] = sleep_mode;
                rdata[STATE_CLKOUT_BIT] = clk_out_enable;
                rdata[STATE_BLANK_BIT] = blank_reg;
                rdata[STATE_PINS_LSB +: 4] = pins_s;
            end
            default: rdata = 16'h0000;
        endcase
    end

    // ----------------------------------------------------------------
    // event flags
    // ----------------------------------------------------------------
    assign alarm_match = (time_count == alarm_compare_value);
    assign alarm_hit = alarm_match && !match_prev_reg && ctrl.day_alarm_enable;
    assign range_bad = ctrl.bipolar_mode
                       ? ((conv_result.value[17:15] != 3'h0) && (conv_result.value[17:15] != 3'h7))
                       : (conv_result.value[17:16] != 2'h0);

    always_comb begin
        set_vec = 16'h0000;
        zero_vec = 16'h0000;
        // level-set flags come straight back if the cause persists
        set_vec[FLAG_LOW_LOGIC] = mon_s[4] && ctrl.logic_monitor_enable;
        zero_vec[FLAG_LOW_LOGIC] = !ctrl.logic_monitor_enable;
        set_vec[FLAG_LOW_PUMP] = mon_s[3] && ctrl.pump_monitor_enable;
        zero_vec[FLAG_LOW_PUMP] = !ctrl.pump_monitor_enable;
        set_vec[FLAG_SIGNAL] = mon_s[2] && ctrl.comparator_power_enable;
        zero_vec[FLAG_SIGNAL] = !ctrl.comparator_power_enable;
        set_vec[FLAG_LOCKED] = lock_rise && ctrl.lock_loop_enable;
        set_vec[FLAG_ALARM] = alarm_hit;
        zero_vec[FLAG_ALARM] = !ctrl.day_alarm_enable;
        set_vec[FLAG_RISE_LSB +: 4] = pin_rise;
        set_vec[FLAG_FALL_LSB +: 4] = pin_fall;
        // only bits that were shifted out are cleared; new events win
        clr_vec = read_done ? (snap_reg & READ_CLEAR_MASK) : 16'h0000;
        flags_next = ((flags_reg & ~clr_vec) | set_vec) & ~zero_vec;
        if (!ctrl.converter_enable) begin
            flags_next[FLAG_RANGE] = 1'b0;
        end else if (conv_result.valid) begin
            flags_next[FLAG_RANGE] = range_bad;
        end else begin
            flags_next[FLAG_RANGE] = flags_reg[FLAG_RANGE];
        end
        flags_next[FLAG_CONV_DONE] = result_ready_signal;
        flags_next[FLAG_UNUSED] = 1'b0;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flags_reg <= EVENT_RESET;
            match_prev_reg <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            match_prev_reg <= alarm_match;
        end
    end

    // ----------------------------------------------------------------
    // read snapshot and interrupt blanking
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            snap_reg <= 16'h0000;
            blank_reg <= 1'b0;
        end else begin
            if (first_data_rise && ev_read) begin
                snap_reg <= flags_reg;
                blank_reg <= 1'b1;
            end else if (read_done || cs_s) begin
                blank_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= !(|(flags_reg & ~mask_reg)) || blank_reg;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask_reg <= MASK_RESET;
            ctrl <= CTRL_RESET;
            pin_cfg_reg <= PIN_CONFIG_RESET;
        end else if (write_strobe) begin
            case (cmd_reg[ADDR_MSB:0])
                ADDR_EVENT_MASK: mask_reg <= wdata & MASK_WRITABLE;
                ADDR_CONTROL: ctrl <= wdata[6:0];
                ADDR_PIN_CONFIG: pin_cfg_reg <= wdata[7:0];
                default: mask_reg <= mask_reg;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // user pins
    // ----------------------------------------------------------------
    always_comb begin
        sleep_pin = 1'b0;
        wake_hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            sleep_pin = sleep_pin || (pins_s[i] && (pin_cfg_reg[2*i +: 2] == PIN_FN_SLEEP));
            wake_hit = wake_hit || (pin_rise[i] && (pin_cfg_reg[2*i +: 2] == PIN_FN_WAKE));
        end
    end

    // routed result output is gated only by the pin function
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            user_pins_out <= 4'h0;
            user_pins_oe <= 4'h0;
            user_pins_pullup <= 4'hF;
        end else begin
            for (int i = 0; i < 4; i++) begin
                user_pins_out[i] <= result_ready_signal
                                    && (pin_cfg_reg[2*i +: 2] == PIN_FN_RESULT_OUT);
                user_pins_oe[i] <= (pin_cfg_reg[2*i +: 2] == PIN_FN_RESULT_OUT);
                user_pins_pullup[i] <= (pin_cfg_reg[2*i +: 2] != PIN_FN_RESULT_OUT);
            end
        end
    end

    // ----------------------------------------------------------------
    // sleep control
    // ----------------------------------------------------------------
    always_comb begin
        latch_next = shutdown_latch;
        if (sleep_cmd || (write_strobe && (cmd_reg[ADDR_MSB:0] == ADDR_SLEEP_CFG)
                          && wdata[SLEEP_REQ_BIT])) begin
            latch_next = 1'b1;
        end else if (!sleep_pin && (normal_cmd || wake_hit || alarm_hit)) begin
            // wake while already awake just clears a clear latch
            latch_next = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shutdown_latch <= 1'b0;
            sleep_mode <= 1'b0;
        end else begin
            shutdown_latch <= latch_next;
            // pin overrides software and wake, leaves latch alone
            sleep_mode <= latch_next || sleep_pin;
        end
    end

    // ----------------------------------------------------------------
    // clock output gate after supervisor timeout
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timeout_cnt_reg <= 32'h0000_0000;
            clk_out_enable <= 1'b0;
        end else if (!mon_s[0]) begin
            timeout_cnt_reg <= 32'h0000_0000;
            clk_out_enable <= 1'b0;
        end else if (timeout_cnt_reg == 32'(TIMEOUT_CYCLES)) begin
            clk_out_enable <= 1'b1;
        end else begin
            timeout_cnt_reg <= timeout_cnt_reg + 32'h0000_0001;
        end
    end

endmodule // event_sleep_control

// ### testbench/event_sleep_sva.sv
// Purpose: port checks for event_sleep_control
// Assumes: pins reach the core through two flip-flops
// Notes: clock-out wait is counted on the raw supervisor level
`timescale 1ns/100ps
module event_sleep_sva
    import event_sleep_pkg::*;
#(parameter int TIMEOUT_US = 100) (
    input wire logic clock, rst, cs_n, miso_oe, supervisor_ok, clk_out_enable,
    input wire logic sleep_mode, result_ready_signal,
    input wire logic [3:0] user_pins_in, user_pins_out, user_pins_oe, user_pins_pullup,
    input wire ctrl_t ctrl
);
    localparam int TMO = TIMEOUT_US * NS_PER_US / CLK_PERIOD_NS;
    logic [15:0] hi_cnt;
    // ----
    // supervisor high time, saturating
    // ----
    always_ff @(posedge clock or posedge rst) begin
        if (rst) hi_cnt <= 16'h0000;
        else hi_cnt <= supervisor_ok ? hi_cnt + {15'h0000, ~&hi_cnt} : 16'h0000;
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (rst);
    sequence sel5; !cs_n [*5]; endsequence
    sequence idle5; cs_n [*5]; endsequence
    a_oe_select: assert property (sel5 |-> miso_oe) else $error("oe low");
    a_oe_idle: assert property (idle5 |-> !miso_oe) else $error("oe high");
    a_pull_oe: assert property (user_pins_pullup == ~user_pins_oe) else $error("pull");
    a_out_mirror:
        assert property (user_pins_out == (user_pins_oe & {4{$past(result_ready_signal)}}))
        else $error("pin out");
    a_clk_drop:
        assert property ($fell(supervisor_ok) |-> ##[1:5] !clk_out_enable) else $error("clk");
    a_clk_wait:
        assert property ($rose(clk_out_enable) |-> hi_cnt >= 16'(TMO)) else $error("early");
    a_sleep_cause:
        assert property ($rose(sleep_mode) |-> !$past(cs_n, 4) || |$past(user_pins_in, 3))
        else $error("sleep");
    a_ctrl_frame: assert property ($changed(ctrl) |-> !$past(cs_n, 3)) else $error("ctrl");
endmodule // event_sleep_sva
bind event_sleep_control event_sleep_sva #(.TIMEOUT_US(TIMEOUT_US)) chk (.*);

// ### testbench/host_link_model.sv
// Purpose: host end of the serial register link
// Assumes: device moves miso after each sclk rise
// Notes: sclk rests low between frames; mosi flips when unused
`timescale 1ns/100ps
module host_link_model (
    output logic sclk = 1'b0,
    output logic cs_n = 1'b1,
    output logic mosi = 1'b0,
    input wire logic miso,
    output logic [15:0] rd_data = 16'h0000,
    output logic rd_tick = 1'b0
);
    // ----
    // one frame, msb first; short count aborts
    // ----
    task automatic frame(input logic [23:0] word, input int nbits);
        logic [15:0] got;
        got = 16'h0000;
        cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            mosi = word[23 - i];
            #80 sclk = 1'b1;
            #80 if (i > 7) got = {got[14:0], miso};
            sclk = 1'b0;
        end
        #80 cs_n = 1'b1;
        mosi = ~mosi;
        if (nbits == 24 && word[23]) begin
            rd_data = got;
            rd_tick = ~rd_tick;
        end
        #80;
    endtask
endmodule // host_link_model

// ### testbench/tb_top.sv
// Purpose: self-checking bench for event_sleep_control
// Assumes: one microsecond timeout keeps clock-out wait short
// Notes: reads are queued and checked by a monitor
`timescale 1ns/100ps
module tb_top
    import event_sleep_pkg::*;
;
    logic clock = 1'b0, rst = 1'b1, miso, miso_oe, irq_n, sleep_mode, clk_out_enable;
    logic sclk, cs_n, mosi, rd_tick, logic_supply_low = 1'b0, pump_output_low = 1'b0;
    logic signal_detect_trip = 1'b0, fll_locked = 1'b0, supervisor_ok = 1'b1;
    logic result_ready_signal = 1'b0;
    logic [3:0] user_pins_in = 4'hF, user_pins_out, user_pins_oe, user_pins_pullup;
    logic [19:0] time_count = 20'h00000, alarm_compare_value = 20'hFFFFF;
    logic [15:0] rd_data, v, exp_q[$];
    conv_result_t conv_result = '0;
    ctrl_t ctrl;
    int miscompares = 0, n_tests = 0, seed = 57309;
    always #4 clock = ~clock;
    host_link_model host (.*);
    event_sleep_control #(.TIMEOUT_US(1)) uut (.*);
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk(input logic b, input logic e);
        cmp({15'h0000, b}, {15'h0000, e});
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host.frame({3'h4, a, 16'h0000}, 24);
    endtask
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(rd_tick) if (exp_q.size() > 0) cmp(rd_data, exp_q.pop_front());
    initial begin
        #500000;
        miscompares++;
        summarize();
    end
    // ----
    // scenarios
    // ----
    initial begin
        step(2);
        rst = 1'b0;
        step(4);
        rd(ADDR_EVENT_MASK, MASK_RESET);
        rd(ADDR_EVENT_FLAGS, EVENT_RESET);
        cmp({9'h000, ctrl}, {9'h000, CTRL_RESET});
        cmp({12'h000, user_pins_pullup}, 16'h000F);
        chk(clk_out_enable, 1'b1);
        supervisor_ok = 1'b0;
        step(6);
        chk(clk_out_enable, 1'b0);
        supervisor_ok = 1'b1;
        v = 16'($random(seed)) & MASK_WRITABLE;
        host.frame({3'h0, ADDR_EVENT_MASK, v}, 24);
        rd(ADDR_EVENT_MASK, v);
        host.frame({3'h0, ADDR_EVENT_MASK, MASK_RESET}, 24);
        $display("done registers");
        user_pins_in = 4'h0;
        step(5);
        user_pins_in = 4'hF;
        step(5);
        chk(irq_n, 1'b1);
        host.frame({8'h80, 16'h0000}, 12);
        rd(ADDR_EVENT_FLAGS, 16'h00FF);
        rd(ADDR_EVENT_FLAGS, 16'h0000);
        host.frame({3'h0, ADDR_CONTROL, 16'h0011}, 24);
        fll_locked = 1'b1;
        step(6);
        chk(irq_n, 1'b0);
        rd(ADDR_EVENT_FLAGS, 16'h0800);
        chk(irq_n, 1'b1);
        $display("done events");
        host.frame({3'h0, ADDR_PIN_CONFIG, 16'h0001}, 24);
        logic_supply_low = 1'b1;
        result_ready_signal = 1'b1;
        step(5);
        chk(user_pins_out[0], 1'b1);
        chk(user_pins_oe[0], 1'b1);
        repeat (2) rd(ADDR_EVENT_FLAGS, 16'h8400);
        logic_supply_low = 1'b0;
        rd(ADDR_EVENT_FLAGS, 16'h8400);
        rd(ADDR_EVENT_FLAGS, 16'h0400);
        result_ready_signal = 1'b0;
        step(3);
        rd(ADDR_EVENT_FLAGS, 16'h0000);
        $display("done levels");
        host.frame({3'h0, ADDR_SLEEP, 16'h0000}, 8);
        chk(sleep_mode, 1'b1);
        host.frame({3'h0, ADDR_NORMAL, 16'h0000}, 8);
        chk(sleep_mode, 1'b0);
        host.frame({3'h0, ADDR_SLEEP_CFG, 16'h0001}, 24);
        host.frame({3'h0, ADDR_PIN_CONFIG, 16'h0038}, 24);
        user_pins_in = 4'h1;
        step(5);
        chk(sleep_mode, 1'b1);
        user_pins_in = 4'h5;
        step(5);
        chk(sleep_mode, 1'b0);
        user_pins_in = 4'h7;
        host.frame({3'h0, ADDR_NORMAL, 16'h0000}, 8);
        chk(sleep_mode, 1'b1);
        user_pins_in = 4'h5;
        step(5);
        chk(sleep_mode, 1'b0);
        $display("done sleep");
        summarize();
    end
endmodule // tb_top
